// >>> verilog/ivc_defs.vh
// Constants of the interrupt vector controller
`ifndef IVC_DEFS_VH
`define IVC_DEFS_VH

// ==========================================
// Sizes
`define IVC_NUM_SRC        20
`define IVC_POS_W          5
`define IVC_PRIO_W         5
`define IVC_ADDR_W         32

// ==========================================
// Fixed exception vectors and priority codes (offset by 3: code 0 is -3)
`define IVC_VEC_RESET      32'h00000004
`define IVC_VEC_NMI        32'h00000008
`define IVC_VEC_HARDFAULT  32'h0000000C
`define IVC_VEC_SVC        32'h0000002C
`define IVC_VEC_PENDED     32'h00000038
`define IVC_VEC_TICK       32'h0000003C
`define IVC_VEC_PERIPH0    32'h00000040
`define IVC_VEC_STEP       32'h00000004
`define IVC_PRIO_RESET     5'h00
`define IVC_PRIO_NMI       5'h01
`define IVC_PRIO_HARDFAULT 5'h02
`define IVC_PRIO_SVC_RST   5'h03
`define IVC_PRIO_PENDED_RST 5'h04
`define IVC_PRIO_TICK_RST  5'h05
`define IVC_PRIO_PERIPH_RST 5'h06

// ==========================================
// Tick calibration: 32 MHz tick clock, 1 ms period
`define IVC_TICK_CLK_KHZ   32000
`define IVC_TICK_PERIOD_MS 1
`define IVC_TICK_CALIB     24'h007D00

// ==========================================
// Source positions
`define IVC_POS_TIMER_ZERO 5'h00
`define IVC_POS_GPIO       5'h01
`define IVC_POS_PARALLEL   5'h02
`define IVC_POS_RADIO_LINK 5'h04
`define IVC_POS_RADIO_BB   5'h05
`define IVC_POS_SERIAL0    5'h0A
`define IVC_POS_LED        5'h0F
`define IVC_POS_SHARED_EVT 5'h13

`endif

// >>> verilog/ivc_prio_sel.v
// Pairwise lowest-priority selector stage
`timescale 1ns/10ps
module ivc_prio_sel (
    // Candidate A
    input  wire       i_a_vld,
    input  wire [4:0] i_a_prio,
    input  wire [5:0] i_a_id,
    // Candidate B
    input  wire       i_b_vld,
    input  wire [4:0] i_b_prio,
    input  wire [5:0] i_b_id,
    // Winner
    output wire       o_vld,
    output wire [4:0] o_prio,
    output wire [5:0] o_id
);
    wire take_b;
    // A wins ties since A always holds the lower id
    assign take_b = i_b_vld & (~i_a_vld | (i_b_prio < i_a_prio));
    assign o_vld  = i_a_vld | i_b_vld;
    assign o_prio = take_b ? i_b_prio : i_a_prio;
    assign o_id   = take_b ? i_b_id : i_a_id;
endmodule

// >>> verilog/ivc_top.v
// Interrupt vector controller: request latching, priority select, vector output
`timescale 1ns/10ps
`include "ivc_defs.vh"
// Behaviour
// - Twenty peripheral sources, each with enable bit and status bit.
// - Report tick calibration constant 32000, one millisecond at 32 MHz.
// - Reset, NMI, hard fault fixed at -3,-2,-1; hard fault vector 0xC.
// - Supervisor call has settable priority, default 0, vector 0x2C.
// - Peripherals at positions 0-19, vectors 0x40..0x8C, default priorities 3-22.
// - Position 1 is general-purpose I/O, vector 0x44.
// - Position 2 is passive parallel port, vector 0x48.
// - Positions 4,5 radio link-layer and baseband; link vector 0x50.
// - Position 10 is serial port zero, vector 0x68.
// - Position 15 is LED screen controller, vector 0x7C.
// - Position 19 combines watchdog and low-battery events.
module ivc_top (
    // Clock and reset
    input  wire        i_ref_clk,
    input  wire        i_srst,
    // Peripheral request lines, bit 19 unused (shared line below)
    input  wire [19:0] i_periph_req,
    input  wire        i_watchdog_req,
    input  wire        i_low_battery_req,
    // System exception requests
    input  wire        i_nmi_req,
    input  wire        i_hardfault_req,
    input  wire        i_supervisor_call_req,
    input  wire        i_pended_service_request,
    input  wire        i_system_tick_timer_req,
    // Per-source controls from the core side
    input  wire [19:0] i_enable_set,
    input  wire [19:0] i_enable_clr,
    input  wire [19:0] i_pend_clr,
    input  wire        i_prio_wr,
    input  wire [5:0]  i_prio_wr_id,
    input  wire [4:0]  i_prio_wr_val,
    // Core acknowledge of presented vector
    input  wire        i_ack,
    // Outputs
    output reg  [19:0] o_enable,
    output reg  [19:0] o_pending,
    output reg         o_irq_vld,
    output reg  [31:0] o_vector_addr,
    output reg  [5:0]  o_irq_id,
    output reg  [4:0]  o_irq_prio,
    output reg  [23:0] o_tick_calib
);
    // ==========================================
    // Id space: 0..19 peripherals, 20 svc, 21 pended, 22 tick, 23 nmi, 24 hardfault
    localparam [5:0] ID_SVC    = 6'h14;
    localparam [5:0] ID_PENDED = 6'h15;
    localparam [5:0] ID_TICK   = 6'h16;
    localparam [5:0] ID_NMI    = 6'h17;
    localparam [5:0] ID_HARD   = 6'h18;
    localparam       NCAND     = 32;

    // ==========================================
    // Synchronise request pins
    reg  [19:0] req_s1_ff;
    reg  [19:0] req_s2_ff;
    reg  [1:0]  evt_s1_ff;
    reg  [1:0]  evt_s2_ff;
    reg  [4:0]  sys_s1_ff;
    reg  [4:0]  sys_s2_ff;
    always @(posedge i_ref_clk) begin
        if (i_srst) begin
            req_s1_ff <= 20'h00000;
            req_s2_ff <= 20'h00000;
            evt_s1_ff <= 2'h0;
            evt_s2_ff <= 2'h0;
            sys_s1_ff <= 5'h00;
            sys_s2_ff <= 5'h00;
        end else begin
            req_s1_ff <= i_periph_req;
            req_s2_ff <= req_s1_ff;
            evt_s1_ff <= {i_low_battery_req, i_watchdog_req};
            evt_s2_ff <= evt_s1_ff;
            sys_s1_ff <= {i_hardfault_req, i_nmi_req, i_system_tick_timer_req,
                          i_pended_service_request, i_supervisor_call_req};
            sys_s2_ff <= sys_s1_ff;
        end
    end

    wire [19:0] src_req;
    assign src_req = {evt_s2_ff[0] | evt_s2_ff[1], req_s2_ff[18:0]};

    // ==========================================
    // Ack decode
    wire        ack_fire;
    assign ack_fire = i_ack & o_irq_vld;

    // ==========================================
    // Per-source enable, status and priority
    reg  [4:0]  prio_ff [0:22];
    reg  [2:0]  sys_pend_ff;
    genvar g;
    generate
        for (g = 0; g < 20; g = g + 1) begin : g_src
            localparam integer PRIO_DEF = `IVC_PRIO_PERIPH_RST + g;
            wire ack_me;
            assign ack_me = ack_fire & (o_irq_id == g);
            always @(posedge i_ref_clk) begin
                if (i_srst) begin
                    o_enable[g]  <= 1'b0;
                    o_pending[g] <= 1'b0;
                    prio_ff[g]   <= PRIO_DEF[4:0];
                end else begin
                    // Set wins over clear
                    if (i_enable_set[g])
                        o_enable[g] <= 1'b1;
                    else if (i_enable_clr[g])
                        o_enable[g] <= 1'b0;
                    if (src_req[g])
                        o_pending[g] <= 1'b1;
                    else if (i_pend_clr[g] | ack_me)
                        o_pending[g] <= 1'b0;
                    if (i_prio_wr && i_prio_wr_id == g && i_prio_wr_val > `IVC_PRIO_HARDFAULT)
                        prio_ff[g] <= i_prio_wr_val;
                end
            end
        end
        for (g = 20; g < 23; g = g + 1) begin : g_sys
            localparam integer PRIO_DEF = `IVC_PRIO_SVC_RST + g - 20;
            wire ack_me;
            assign ack_me = ack_fire & (o_irq_id == g);
            always @(posedge i_ref_clk) begin
                if (i_srst) begin
                    sys_pend_ff[g-20] <= 1'b0;
                    prio_ff[g]        <= PRIO_DEF[4:0];
                end else begin
                    if (sys_s2_ff[g-20])
                        sys_pend_ff[g-20] <= 1'b1;
                    else if (ack_me)
                        sys_pend_ff[g-20] <= 1'b0;
                    if (i_prio_wr && i_prio_wr_id == g && i_prio_wr_val > `IVC_PRIO_HARDFAULT)
                        prio_ff[g] <= i_prio_wr_val;
                end
            end
        end
    endgenerate

    reg [1:0] fix_pend_ff;
    always @(posedge i_ref_clk) begin
        if (i_srst) begin
            fix_pend_ff <= 2'h0;
        end else begin
            if (sys_s2_ff[3])
                fix_pend_ff[0] <= 1'b1;
            else if (ack_fire && o_irq_id == ID_NMI)
                fix_pend_ff[0] <= 1'b0;
            if (sys_s2_ff[4])
                fix_pend_ff[1] <= 1'b1;
            else if (ack_fire && o_irq_id == ID_HARD)
                fix_pend_ff[1] <= 1'b0;
        end
    end

    // ==========================================
    // Candidate vector and tournament tree, lower id always on the A side
    wire        c_vld  [0:2*NCAND-2];
    wire [4:0]  c_prio [0:2*NCAND-2];
    wire [5:0]  c_id   [0:2*NCAND-2];
    generate
        for (g = 0; g < NCAND; g = g + 1) begin : g_leaf
            localparam integer LEAF_ID = g;
            if (g < 20) begin : g_p
                assign c_vld[NCAND-1+g] = o_pending[g] & o_enable[g];
                assign c_prio[NCAND-1+g] = prio_ff[g];
            end else if (g < 23) begin : g_s
                assign c_vld[NCAND-1+g] = sys_pend_ff[g-20];
                assign c_prio[NCAND-1+g] = prio_ff[g];
            end else if (g == 23) begin : g_n
                assign c_vld[NCAND-1+g] = fix_pend_ff[0];
                assign c_prio[NCAND-1+g] = `IVC_PRIO_NMI;
            end else if (g == 24) begin : g_h
                assign c_vld[NCAND-1+g] = fix_pend_ff[1];
                assign c_prio[NCAND-1+g] = `IVC_PRIO_HARDFAULT;
            end else begin : g_z
                assign c_vld[NCAND-1+g] = 1'b0;
                assign c_prio[NCAND-1+g] = 5'h1F;
            end
            assign c_id[NCAND-1+g] = LEAF_ID[5:0];
        end
        for (g = 0; g < NCAND-1; g = g + 1) begin : g_node
            ivc_prio_sel u_sel (
                .i_a_vld  (c_vld[2*g+1]),
                .i_a_prio (c_prio[2*g+1]),
                .i_a_id   (c_id[2*g+1]),
                .i_b_vld  (c_vld[2*g+2]),
                .i_b_prio (c_prio[2*g+2]),
                .i_b_id   (c_id[2*g+2]),
                .o_vld    (c_vld[g]),
                .o_prio   (c_prio[g]),
                .o_id     (c_id[g])
            );
        end
    endgenerate

    // ==========================================
    // Vector address of the winner
    reg [31:0] nxt_vec;
    always @* begin
        nxt_vec = `IVC_VEC_PERIPH0 + {26'h0000000, c_id[0]} * `IVC_VEC_STEP;
        case (c_id[0])
            ID_SVC:    nxt_vec = `IVC_VEC_SVC;
            ID_PENDED: nxt_vec = `IVC_VEC_PENDED;
            ID_TICK:   nxt_vec = `IVC_VEC_TICK;
            ID_NMI:    nxt_vec = `IVC_VEC_NMI;
            ID_HARD:   nxt_vec = `IVC_VEC_HARDFAULT;
            default:   nxt_vec = `IVC_VEC_PERIPH0 + {26'h0000000, c_id[0]} * `IVC_VEC_STEP;
        endcase
    end

    // ==========================================
    // Registered outputs; suppressed the cycle after an ack so cleared flags settle
    always @(posedge i_ref_clk) begin
        if (i_srst) begin
            o_irq_vld     <= 1'b0;
            o_vector_addr <= `IVC_VEC_RESET;
            o_irq_id      <= 6'h3F;
            o_irq_prio    <= `IVC_PRIO_RESET;
            o_tick_calib  <= 24'h000000;
        end else begin
            o_irq_vld     <= c_vld[0] & ~ack_fire;
            o_vector_addr <= nxt_vec;
            o_irq_id      <= c_id[0];
            o_irq_prio    <= c_prio[0];
            o_tick_calib  <= `IVC_TICK_CALIB;
        end
    end
endmodule

// >>> dv/ivc_checker.sv
// Port checker of the interrupt vector controller
`timescale 1ns/10ps
module ivc_checker (
    // Clock, reset and request inputs
    input wire        i_ref_clk,
    input wire        i_srst,
    input wire        i_watchdog_req,
    input wire        i_low_battery_req,
    input wire        i_ack,
    // Outputs watched
    input wire [19:0] o_enable,
    input wire [19:0] o_pending,
    input wire        o_irq_vld,
    input wire [31:0] o_vector_addr,
    input wire [5:0]  o_irq_id,
    input wire [4:0]  o_irq_prio,
    input wire [23:0] o_tick_calib
);
    // ==========================================
    // Assertions
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_srst);
    calib_value_a: assert property (!i_srst |=> o_tick_calib == 24'h007D00) else $error("calib wrong");
    periph_vector_a: assert property (o_irq_vld && o_irq_id < 6'h14 |->
        o_vector_addr == 32'h00000040 + {o_irq_id, 2'b00}) else $error("vector wrong");
    svc_vector_a: assert property (o_irq_vld && o_irq_id == 6'h14 |-> o_vector_addr == 32'h0000002C)
        else $error("svc vector wrong");
    nmi_fixed_a: assert property (o_irq_vld && o_irq_id == 6'h17 |->
        o_irq_prio == 5'h01 && o_vector_addr == 32'h00000008) else $error("nmi wrong");
    fault_fixed_a: assert property (o_irq_vld && o_irq_id == 6'h18 |->
        o_irq_prio == 5'h02 && o_vector_addr == 32'h0000000C) else $error("fault wrong");
    enabled_only_a: assert property ($rose(o_irq_vld) && o_irq_id < 6'h14 |->
        o_enable[o_irq_id] && o_pending[o_irq_id]) else $error("disabled presented");
    hold_until_ack_a: assert property (o_irq_vld && !i_ack |=> o_irq_vld && $stable(o_vector_addr))
        else $error("vector dropped");
    ack_drop_a: assert property (o_irq_vld && i_ack |=> !o_irq_vld) else $error("ack ignored");
    shared_line_a: assert property ($rose(i_watchdog_req | i_low_battery_req) |-> ##[1:4] o_pending[19])
        else $error("shared line lost");
    cover property (o_irq_vld && o_irq_id == 6'h13);
    cover property (o_irq_vld && i_ack);
    cover property (o_irq_vld && o_irq_id == 6'h18);
endmodule

// >>> dv/ivc_core_model.sv
// Core-side model that takes presented vectors
`timescale 1ns/10ps
module ivc_core_model (
    // Clock and reset
    input  wire i_ref_clk,
    input  wire i_srst,
    // Handshake
    input  wire i_irq_vld,
    input  wire i_stall,
    output reg  o_ack
);
    initial o_ack = 1'b0;
    // One-cycle ack only while a vector stands, never twice in a row
    always @(posedge i_ref_clk) begin
        o_ack <= #1 !i_srst && i_irq_vld && !o_ack && !i_stall;
    end
endmodule

// >>> dv/test_interrupt_vector_controller.sv
// Self-checking bench of the interrupt vector controller
`timescale 1ns/10ps
module test_interrupt_vector_controller;
    reg         i_ref_clk = 1'b0;
    reg         i_srst = 1'b1;
    reg  [19:0] req = 20'h0, en_set = 20'h0, en_clr = 20'h0, p_clr = 20'h0;
    reg  [1:0]  wd = 2'h0;
    reg  [4:0]  exc = 5'h0, pw_val = 5'h0;
    reg  [5:0]  pw_id = 6'h0;
    reg         pw = 1'b0, stall = 1'b1;
    wire        ack, o_irq_vld;
    wire [19:0] o_enable, o_pending;
    wire [31:0] o_vector_addr;
    wire [5:0]  o_irq_id;
    wire [4:0]  o_irq_prio;
    wire [23:0] o_tick_calib;
    reg  [4:0]  prio_m [0:24];
    integer     fails = 0, checked = 0, cyc = 0, k, r;
    ivc_top ivc_top_i (.i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_periph_req(req), .i_watchdog_req(wd[0]),
        .i_low_battery_req(wd[1]), .i_nmi_req(exc[3]), .i_hardfault_req(exc[4]), .i_supervisor_call_req(exc[0]),
        .i_pended_service_request(exc[1]), .i_system_tick_timer_req(exc[2]), .i_enable_set(en_set),
        .i_enable_clr(en_clr), .i_pend_clr(p_clr), .i_prio_wr(pw), .i_prio_wr_id(pw_id), .i_prio_wr_val(pw_val),
        .i_ack(ack), .o_enable(o_enable), .o_pending(o_pending), .o_irq_vld(o_irq_vld),
        .o_vector_addr(o_vector_addr), .o_irq_id(o_irq_id), .o_irq_prio(o_irq_prio), .o_tick_calib(o_tick_calib));
    ivc_core_model ivc_core_model_i (.i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_irq_vld(o_irq_vld),
        .i_stall(stall), .o_ack(ack));
    // ==========================================
    // Helpers
    initial begin
        forever #2 i_ref_clk = ~i_ref_clk;
    end
    task tick();
        @(posedge i_ref_clk);
        #1;
    endtask
    task chk(input [31:0] seen, input [31:0] exp);
        checked = checked + 1;
        if (seen !== exp) begin
            fails = fails + 1;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    function [5:0] exp_win(input [24:0] m);
        integer i;
        exp_win = 6'h3F;
        for (i = 0; i < 25; i = i + 1)
            if (m[i] && (exp_win == 6'h3F || prio_m[i] < prio_m[exp_win])) exp_win = 6'(i);
    endfunction
    function [31:0] exp_vec(input [5:0] id);
        case (id)
            6'h14: exp_vec = 32'h0000002C;
            6'h15: exp_vec = 32'h00000038;
            6'h16: exp_vec = 32'h0000003C;
            6'h17: exp_vec = 32'h00000008;
            6'h18: exp_vec = 32'h0000000C;
            default: exp_vec = 32'h00000040 + {id, 2'b00};
        endcase
    endfunction
    task prio_write(input [5:0] id, input [4:0] v);
        pw = 1'b1;
        pw_id = id;
        pw_val = v;
        tick;
        pw = 1'b0;
        if (id <= 6'h16 && v > 5'h02) prio_m[id] = v;
        tick;
    endtask
    task round(input [19:0] en, input [19:0] rq, input [1:0] w, input [4:0] ex);
        reg [19:0] pv;
        reg [5:0]  id;
        pv = (rq & 20'h7FFFF) | {w != 2'h0, 19'h0};
        id = exp_win({ex, en & pv});
        en_set = en;
        en_clr = 20'hFFFFF;
        tick;
        en_set = 20'h0;
        en_clr = 20'h0;
        req = rq;
        wd = w;
        exc = ex;
        repeat (8) tick;
        chk(o_enable, en);
        chk(o_pending, pv);
        chk(o_irq_vld, id != 6'h3F);
        if (id != 6'h3F) begin
            chk(o_irq_id, id);
            chk(o_irq_prio, prio_m[id]);
            chk(o_vector_addr, exp_vec(id));
        end
        req = 20'h0;
        wd = 2'h0;
        exc = 5'h0;
        repeat (4) tick;
        p_clr = 20'hFFFFF;
        stall = 1'b0;
        tick;
        p_clr = 20'h0;
        repeat (16) tick;
        chk(o_irq_vld, 1'b0);
        chk(o_pending, 20'h0);
        stall = 1'b1;
    endtask
    task end_sim();
        if (fails == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    always @(posedge i_ref_clk) begin
        cyc = cyc + 1;
        if (cyc == 6000) begin
            fails = fails + 1;
            end_sim;
        end
    end
    // ==========================================
    // Scenarios
    initial begin
        for (k = 0; k < 25; k = k + 1) prio_m[k] = 5'(k < 20 ? k + 6 : k < 23 ? k - 17 : k - 22);
        r = $urandom(53211);
        repeat (2) tick;
        i_srst = 1'b0;
        tick;
        chk(o_tick_calib, 24'h007D00);
        for (k = 0; k < 5; k = k + 1) round(20'h0, 20'h0, 2'h0, 5'(1 << k));
        for (k = 0; k < 19; k = k + 1) round(20'(1 << k), 20'(1 << k), 2'h0, 5'h0);
        round(20'h80000, 20'h0, 2'h1, 5'h0);
        round(20'h80000, 20'h0, 2'h2, 5'h0);
        round(20'h00010, 20'h00013, 2'h0, 5'h0);
        prio_write(6'h07, 5'h09);
        prio_write(6'h00, 5'h02);
        round(20'h00089, 20'h00088, 2'h0, 5'h0);
        for (k = 0; k < 30; k = k + 1) begin
            prio_write(6'($urandom), 5'($urandom));
            round(20'($urandom), 20'($urandom), 2'($urandom), 5'($urandom));
        end
        end_sim;
    end
endmodule
bind ivc_top ivc_checker ivc_checker_i (.i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_watchdog_req(i_watchdog_req),
    .i_low_battery_req(i_low_battery_req), .i_ack(i_ack), .o_enable(o_enable), .o_pending(o_pending),
    .o_irq_vld(o_irq_vld), .o_vector_addr(o_vector_addr), .o_irq_id(o_irq_id), .o_irq_prio(o_irq_prio),
    .o_tick_calib(o_tick_calib));
